// File: rtl/rx_path_gain_filter_adc_control.sv
// Behaviour
// - six-bit gain code selects -12 dB to +48 dB in 1 dB steps.
// - alternative three-bit mapping covers -12 dB to +36 dB in 8 dB steps.
// - coarse section is two cascaded stages in 6 dB steps; first stage fills before second moves.
// - fine stage adds 0 dB to 6 dB in 1 dB steps.
// - a lookup table splits the overall gain into per-stage settings.
// - offset cancellation runs after reset and again on a serial request.
// - during cancellation first stage input shorted, all stages forced to high gain.
// - servo steps calibration DAC until offset lies within plus or minus 32 LSB.
// - every cutoff target write starts a filter calibration lasting 100 us.
// - filter enable bit 0 of control register resets active; clearing bypasses filter.
// - bit 4 of control register selects reduced-current converter mode.
// - bits 2 to 0 of bias register select converter bias setting.
// - converter powers down in half-duplex while the receive path is unused.
// - half-duplex bus shows a sample 10.0 converter clocks after input.
// - full-duplex bus shows a sample's high half 10.0 converter clocks after input, low half once the bus accepts the high half.
// - twelve-bit samples pass through 10 delay stages, one stage per valid sample while the buffer has room.
// - bit 4 of clock register selects PLL-derived converter clock, else reference.
module rx_path_gain_filter_adc_control
	import rx_ctrl_pkg::*;
#(
	parameter int CAL_CYCLES = CUTOFF_CAL_CYCLES,
	parameter int PIPE_STAGES = BUS_PIPE_STAGES
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce,
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_din,
	output logic spi_dout,
	output logic spi_dout_oe,
	input wire logic [5:0] gain_code,
	input wire logic gain_map_alt,
	input wire logic duplex_full,
	input wire logic rx_unused,
	input wire logic adc_valid,
	input wire logic [ADC_BITS-1:0] adc_sample,
	output gain_set_t receive_gain_amp,
	output logic input_short,
	output logic [7:0] offset_dac,
	output logic filter_bypass,
	output logic [7:0] cutoff_target,
	output logic cutoff_cal_start,
	output logic cutoff_cal_busy,
	output logic adc_low_power,
	output logic [2:0] adc_bias,
	output logic adc_clk_from_pll,
	output logic adc_power_down,
	output logic [ADC_BITS-1:0] converter_data_bus,
	output logic bus_valid,
	output logic bus_second_nibble,
	input wire logic bus_ready
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [10:0] pin_meta_q;
	logic [10:0] pin_q;
	logic spi_clk_prev_q;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_meta_q <= 11'h000;
			pin_q <= 11'h000;
			spi_clk_prev_q <= 1'b0;
		end
		else if (ce)
		begin
			pin_meta_q <= {gain_code, gain_map_alt, duplex_full, rx_unused,
				spi_clk, spi_din};
			pin_q <= pin_meta_q;
			spi_clk_prev_q <= pin_q[1];
		end
	end

	// bit 1 carries the serial clock; chip select is sampled separately below
	logic spi_cs_meta_q;
	logic spi_cs_q;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			spi_cs_meta_q <= 1'b1;
			spi_cs_q <= 1'b1;
		end
		else if (ce)
		begin
			spi_cs_meta_q <= spi_cs_n;
			spi_cs_q <= spi_cs_meta_q;
		end
	end

	logic [5:0] gain_code_s;
	logic gain_alt_s;
	logic duplex_full_s;
	logic rx_unused_s;
	logic spi_clk_s;
	logic spi_din_s;
	logic spi_rise;
	logic spi_fall;

	assign gain_code_s = pin_q[10:5];
	assign gain_alt_s = pin_q[4];
	assign duplex_full_s = pin_q[3];
	assign rx_unused_s = pin_q[2];
	assign spi_clk_s = pin_q[1];
	assign spi_din_s = pin_q[0];
	assign spi_rise = spi_clk_s && !spi_clk_prev_q && !spi_cs_q;
	assign spi_fall = !spi_clk_s && spi_clk_prev_q && !spi_cs_q;

	// ------------------------------------------------------------
	// serial port: read flag, 7-bit address, 8-bit data, msb first
	// ------------------------------------------------------------
	logic [3:0] bit_cnt_q;
	logic [14:0] shift_in_q;
	logic [7:0] shift_out_q;
	logic read_active_q;
	logic wr_stb_q;
	logic [6:0] wr_addr_q;
	logic [7:0] wr_data_q;
	logic [7:0] clock_config_q;
	logic [7:0] filter_adc_q;
	logic [7:0] adc_bias_q;
	logic ofs_busy;
	logic [7:0] read_data;
	logic [6:0] rd_addr;

	assign rd_addr = {shift_in_q[5:0], spi_din_s};

	always_comb
	begin
		case (rd_addr)
			ADDR_CLOCK_CONFIG: read_data = clock_config_q;
			ADDR_FILTER_ADC: read_data = filter_adc_q;
			ADDR_CUTOFF_TARGET: read_data = cutoff_target;
			ADDR_ADC_BIAS: read_data = adc_bias_q;
			ADDR_CAL_CONTROL: read_data = {6'h00, cutoff_cal_busy, ofs_busy};
			default: read_data = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			bit_cnt_q <= 4'h0;
			shift_in_q <= 15'h0000;
			shift_out_q <= 8'h00;
			read_active_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_addr_q <= 7'h00;
			wr_data_q <= 8'h00;
			spi_dout <= 1'b0;
			spi_dout_oe <= 1'b0;
		end
		else if (ce)
		begin
			wr_stb_q <= 1'b0;
			if (spi_cs_q)
			begin
				bit_cnt_q <= 4'h0;
				read_active_q <= 1'b0;
				spi_dout_oe <= 1'b0;
			end
			else if (spi_rise)
			begin
				shift_in_q <= {shift_in_q[13:0], spi_din_s};
				bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
				if (bit_cnt_q == SPI_ADDR_DONE_BIT && shift_in_q[6])
				begin
					read_active_q <= 1'b1;
					shift_out_q <= read_data;
				end
				if (bit_cnt_q == SPI_LAST_BIT && !shift_in_q[14])
				begin
					wr_stb_q <= 1'b1;
					wr_addr_q <= shift_in_q[13:7];
					wr_data_q <= {shift_in_q[6:0], spi_din_s};
				end
			end
			else if (spi_fall && read_active_q)
			begin
				spi_dout <= shift_out_q[7];
				spi_dout_oe <= 1'b1;
				shift_out_q <= {shift_out_q[6:0], 1'b0};
			end
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic cutoff_write;
	logic ofs_request;

	assign cutoff_write = wr_stb_q && (wr_addr_q == ADDR_CUTOFF_TARGET);
	assign ofs_request = wr_stb_q && (wr_addr_q == ADDR_CAL_CONTROL) && wr_data_q[OFS_START_BIT];

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			clock_config_q <= CLOCK_CONFIG_RST;
			filter_adc_q <= FILTER_ADC_RST;
			cutoff_target <= CUTOFF_TARGET_RST;
			adc_bias_q <= ADC_BIAS_RST;
		end
		else if (ce && wr_stb_q)
		begin
			case (wr_addr_q)
				ADDR_CLOCK_CONFIG: clock_config_q <= wr_data_q;
				ADDR_FILTER_ADC: filter_adc_q <= wr_data_q;
				ADDR_CUTOFF_TARGET: cutoff_target <= wr_data_q;
				ADDR_ADC_BIAS: adc_bias_q <= wr_data_q;
				default: clock_config_q <= clock_config_q;
			endcase
		end
	end

	// analog controls follow their register bits; power-down follows the duplex and unused pins
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			filter_bypass <= ~FILTER_ADC_RST[FILTER_EN_BIT];
			adc_low_power <= FILTER_ADC_RST[ADC_LOW_POWER_BIT];
			adc_bias <= ADC_BIAS_RST[BIAS_MSB:0];
			adc_clk_from_pll <= CLOCK_CONFIG_RST[ADC_CLK_PLL_BIT];
			adc_power_down <= 1'b0;
		end
		else if (ce)
		begin
			filter_bypass <= ~filter_adc_q[FILTER_EN_BIT];
			adc_low_power <= filter_adc_q[ADC_LOW_POWER_BIT];
			adc_bias <= adc_bias_q[BIAS_MSB:0];
			adc_clk_from_pll <= clock_config_q[ADC_CLK_PLL_BIT];
			adc_power_down <= !duplex_full_s && rx_unused_s;
		end
	end

	// ------------------------------------------------------------
	// cutoff calibration timer
	// ------------------------------------------------------------
	logic [15:0] cal_cnt_q;

	// a rewrite while busy restarts the timer, so a drift recalibration is never skipped
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cal_cnt_q <= 16'h0000;
			cutoff_cal_start <= 1'b0;
			cutoff_cal_busy <= 1'b0;
		end
		else if (ce)
		begin
			cutoff_cal_start <= cutoff_write;
			if (cutoff_write)
			begin
				cal_cnt_q <= 16'(CAL_CYCLES - 1);
				cutoff_cal_busy <= 1'b1;
			end
			else if (cal_cnt_q != 16'h0000)
			begin
				cal_cnt_q <= 16'(cal_cnt_q - 16'h0001);
			end
			else
			begin
				cutoff_cal_busy <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// gain lookup table
	// ------------------------------------------------------------
	function automatic gain_set_t gain_lookup_table(input logic [5:0] code, input logic alt);
		logic [5:0] idx;
		logic [3:0] coarse;
		gain_set_t g;
		if (alt)
		begin
			idx = 6'((code[2:0] > ALT_MAX_CODE ? ALT_MAX_CODE : code[2:0]) * ALT_STEP_DB);
		end
		else
		begin
			idx = (code > GAIN_MAX_IDX) ? GAIN_MAX_IDX : code;
		end
		coarse = 4'(idx / COARSE_STEP_DB);
		if (coarse > COARSE_MAX_IDX)
		begin
			coarse = COARSE_MAX_IDX;
		end
		g.first_stage = (coarse > 4'(FIRST_STAGE_MAX)) ? FIRST_STAGE_MAX : coarse[2:0];
		g.second_stage = 3'(coarse - 4'(g.first_stage));
		g.fine = 3'(idx - 6'(coarse * COARSE_STEP_DB));
		return g;
	endfunction

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			receive_gain_amp <= '0;
		end
		else if (ce)
		begin
			if (ofs_busy)
			begin
				receive_gain_amp <= {FIRST_STAGE_MAX, SECOND_STAGE_MAX, FINE_MAX};
			end
			else
			begin
				// one register for all stages so no mixed gain is ever seen
				receive_gain_amp <= gain_lookup_table(gain_code_s, gain_alt_s);
			end
		end
	end

	// ------------------------------------------------------------
	// offset cancellation servo
	// ------------------------------------------------------------
	offset_state_t ofs_state_q;
	logic ofs_pending_q;
	logic [3:0] settle_q;
	logic signed [ADC_BITS-1:0] sample_s;

	assign ofs_busy = (ofs_state_q != OFS_IDLE);
	assign sample_s = adc_sample;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ofs_state_q <= OFS_IDLE;
			ofs_pending_q <= 1'b1;
			settle_q <= 4'h0;
			offset_dac <= 8'h00;
			input_short <= 1'b0;
		end
		else if (ce)
		begin
			// request during a run is held and served afterwards
			if (ofs_request)
			begin
				ofs_pending_q <= 1'b1;
			end
			case (ofs_state_q)
				OFS_IDLE:
				begin
					input_short <= 1'b0;
					if (ofs_pending_q && !ofs_request)
					begin
						ofs_pending_q <= 1'b0;
						ofs_state_q <= OFS_SETTLE;
						input_short <= 1'b1;
						settle_q <= OFS_SETTLE_SAMPLES;
					end
				end
				OFS_SETTLE:
				begin
					if (adc_valid)
					begin
						settle_q <= 4'(settle_q - 4'h1);
						if (settle_q == 4'h1)
						begin
							ofs_state_q <= OFS_MEASURE;
						end
					end
				end
				OFS_MEASURE:
				begin
					if (adc_valid)
					begin
						// one dac step per decision, then re-settle; a pinned dac ends the run
						if (sample_s > 12'(OFFSET_TOL_LSB) && offset_dac != 8'h80)
						begin
							offset_dac <= 8'(offset_dac - 8'h01);
							ofs_state_q <= OFS_SETTLE;
							settle_q <= OFS_SETTLE_SAMPLES;
						end
						else if (sample_s < -12'(OFFSET_TOL_LSB) && offset_dac != 8'h7F)
						begin
							offset_dac <= 8'(offset_dac + 8'h01);
							ofs_state_q <= OFS_SETTLE;
							settle_q <= OFS_SETTLE_SAMPLES;
						end
						else
						begin
							ofs_state_q <= OFS_IDLE;
							input_short <= 1'b0;
						end
					end
				end
				default: ofs_state_q <= OFS_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// converter pipeline and output bus
	// ------------------------------------------------------------
	logic [ADC_BITS-1:0] pipe_q [PIPE_STAGES];
	logic [PIPE_STAGES-1:0] pipe_v_q;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [ADC_BITS-1:0] buf_out_data;
	logic advance;
	logic capture;
	logic nibble_pend_q;
	logic [5:0] low_nibble_q;

	assign capture = !ofs_busy && !adc_power_down;
	// a full buffer freezes the whole pipeline so no stored word is overwritten
	assign advance = adc_valid && buf_in_ready;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pipe_v_q <= '0;
		end
		else if (ce && advance)
		begin
			pipe_v_q <= {pipe_v_q[PIPE_STAGES-2:0], capture};
		end
	end

	always_ff @(posedge clock)
	begin
		if (ce && advance)
		begin
			pipe_q[0] <= adc_sample;
			for (int i = 1; i < PIPE_STAGES; i++)
			begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end

	two_entry_buffer #(.WIDTH(ADC_BITS)) u_buffer (
		.clock(clock),
		.resetn(resetn),
		.ce(ce),
		.in_valid(advance && pipe_v_q[PIPE_STAGES-1]),
		.in_ready(buf_in_ready),
		.in_data(pipe_q[PIPE_STAGES-1]),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	assign buf_out_ready = (!bus_valid || bus_ready) && !nibble_pend_q;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			converter_data_bus <= '0;
			bus_valid <= 1'b0;
			bus_second_nibble <= 1'b0;
			nibble_pend_q <= 1'b0;
			low_nibble_q <= 6'h00;
		end
		else if (ce && (!bus_valid || bus_ready))
		begin
			if (nibble_pend_q)
			begin
				converter_data_bus <= {6'h00, low_nibble_q};
				bus_valid <= 1'b1;
				bus_second_nibble <= 1'b1;
				nibble_pend_q <= 1'b0;
			end
			else if (buf_out_valid && duplex_full_s)
			begin
				// full duplex splits each word; the low half follows once the bus accepts the high half
				converter_data_bus <= {6'h00, buf_out_data[11:6]};
				low_nibble_q <= buf_out_data[5:0];
				bus_valid <= 1'b1;
				bus_second_nibble <= 1'b0;
				nibble_pend_q <= 1'b1;
			end
			else
			begin
				converter_data_bus <= buf_out_data;
				bus_valid <= buf_out_valid;
				bus_second_nibble <= 1'b0;
			end
		end
	end

endmodule

// File: rtl/two_entry_buffer.sv
module two_entry_buffer
	import rx_ctrl_pkg::*;
#(
	parameter int WIDTH = ADC_BITS
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	logic [WIDTH-1:0] mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready && ce;
	assign pop = out_valid && out_ready && ce;

	always_ff @(posedge clock)
	begin
		if (push)
		begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop)
			begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
		end
	end

endmodule

// File: shared/rx_ctrl_pkg.sv
package rx_ctrl_pkg;

	// ------------------------------------------------------------
	// register offsets (7-bit serial address)
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR_CLOCK_CONFIG = 7'h04;
	localparam logic [6:0] ADDR_FILTER_ADC = 7'h07;
	localparam logic [6:0] ADDR_CUTOFF_TARGET = 7'h08;
	localparam logic [6:0] ADDR_ADC_BIAS = 7'h13;
	localparam logic [6:0] ADDR_CAL_CONTROL = 7'h15;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int ADC_CLK_PLL_BIT = 4;
	localparam int FILTER_EN_BIT = 0;
	localparam int ADC_LOW_POWER_BIT = 4;
	localparam int BIAS_MSB = 2;
	localparam int OFS_START_BIT = 0;
	localparam logic [7:0] CLOCK_CONFIG_RST = 8'h00;
	localparam logic [7:0] FILTER_ADC_RST = 8'h01;
	localparam logic [7:0] CUTOFF_TARGET_RST = 8'h80;
	localparam logic [7:0] ADC_BIAS_RST = 8'h00;

	// ------------------------------------------------------------
	// gain mapping
	// ------------------------------------------------------------
	localparam logic [5:0] GAIN_MAX_IDX = 6'h3C;
	localparam logic [2:0] ALT_MAX_CODE = 3'h6;
	localparam logic [5:0] ALT_STEP_DB = 6'h08;
	localparam logic [5:0] COARSE_STEP_DB = 6'h06;
	localparam logic [3:0] COARSE_MAX_IDX = 4'h9;
	localparam logic [2:0] FIRST_STAGE_MAX = 3'h4;
	localparam logic [2:0] SECOND_STAGE_MAX = 3'h5;
	localparam logic [2:0] FINE_MAX = 3'h6;

	// ------------------------------------------------------------
	// offset servo, converter, serial port
	// ------------------------------------------------------------
	localparam int OFFSET_TOL_LSB = 32;
	localparam logic [3:0] OFS_SETTLE_SAMPLES = 4'h4;
	localparam int ADC_BITS = 12;
	localparam int BUS_PIPE_STAGES = 10;
	localparam logic [3:0] SPI_LAST_BIT = 4'hF;
	localparam logic [3:0] SPI_ADDR_DONE_BIT = 4'h7;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int CUTOFF_CAL_TIME_US = 100;
	localparam int CUTOFF_CAL_CYCLES = (CUTOFF_CAL_TIME_US * 1000000) / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] first_stage;
		logic [2:0] second_stage;
		logic [2:0] fine;
	} gain_set_t;

	typedef enum logic [1:0] {OFS_IDLE, OFS_SETTLE, OFS_MEASURE} offset_state_t;

endpackage

// File: verif/baseband_sink.sv
module baseband_sink
	import rx_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [1:0] stall_mode,
	input wire logic duplex,
	input wire logic bus_valid,
	input wire logic [ADC_BITS-1:0] converter_data_bus,
	input wire logic bus_second_nibble,
	output logic bus_ready,
	output logic [ADC_BITS-1:0] word,
	output logic word_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] tick_q;
	logic [5:0] high_q;
	// ------
	// mode 0 ready, 1 stalls 3 of 8 cycles, 2 never ready (fills the buffer)
	// ------
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			tick_q <= 3'h0;
		else
			tick_q <= tick_q + 3'h1;
	end
	assign bus_ready = (stall_mode == 2'h0) || (stall_mode == 2'h1 && tick_q > 3'h2);
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			word_valid <= 1'b0;
			high_q <= 6'h00;
			word <= 12'h000;
		end
		else
		begin
			word_valid <= 1'b0;
			if (bus_valid && bus_ready && !duplex)
			begin
				word <= converter_data_bus;
				word_valid <= 1'b1;
			end
			else if (bus_valid && bus_ready && !bus_second_nibble)
				high_q <= converter_data_bus[5:0];
			else if (bus_valid && bus_ready)
			begin
				word <= {high_q, converter_data_bus[5:0]};
				word_valid <= 1'b1;
			end
		end
	end
endmodule

// File: verif/rx_ctrl_properties.sv
module rx_ctrl_properties
	import rx_ctrl_pkg::*;
#(
	parameter int CAL_CYCLES = CUTOFF_CAL_CYCLES
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic spi_cs_n,
	input wire logic spi_dout_oe,
	input wire gain_set_t receive_gain_amp,
	input wire logic input_short,
	input wire logic [7:0] offset_dac,
	input wire logic cutoff_cal_start,
	input wire logic cutoff_cal_busy,
	input wire logic [ADC_BITS-1:0] converter_data_bus,
	input wire logic bus_valid,
	input wire logic bus_second_nibble,
	input wire logic bus_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int busy_cnt_q;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// ------
	// busy length, restarted by every target write so a rewrite is not flagged
	// ------
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			busy_cnt_q <= 0;
		else if (cutoff_cal_start)
			busy_cnt_q <= 0;
		else if (cutoff_cal_busy)
			busy_cnt_q <= busy_cnt_q + 1;
	end
	// ------
	// properties
	// ------
	chk_cal_start_busy: assert property (cutoff_cal_start |=> cutoff_cal_busy && !cutoff_cal_start)
		else $error("cutoff calibration start without busy");
	chk_cal_time_bound: assert property (busy_cnt_q <= CAL_CYCLES)
		else $error("cutoff calibration too long");
	chk_powerup_offset_run: assert property ($rose(resetn) |-> ##[1:3] input_short)
		else $error("no offset run after reset");
	chk_gain_forced_cal: assert property (input_short && $past(input_short)
		|-> receive_gain_amp == {FIRST_STAGE_MAX, SECOND_STAGE_MAX, FINE_MAX})
		else $error("gain not forced high during offset run");
	chk_stage_split: assert property (!input_short |-> receive_gain_amp.fine <= FINE_MAX
		&& receive_gain_amp.second_stage <= SECOND_STAGE_MAX
		&& (receive_gain_amp.second_stage == 3'h0 || receive_gain_amp.first_stage == FIRST_STAGE_MAX))
		else $error("illegal stage split");
	chk_dac_single_step: assert property ($changed(offset_dac)
		|-> 8'(offset_dac - $past(offset_dac)) inside {8'h01, 8'hFF})
		else $error("offset dac moved more than one step");
	chk_dac_frozen_idle: assert property (!input_short && !$past(input_short)
		&& !$past(input_short, 2) |-> $stable(offset_dac))
		else $error("offset dac moved outside offset run");
	chk_bus_word_hold: assert property (bus_valid && !bus_ready
		|=> bus_valid && $stable(converter_data_bus) && $stable(bus_second_nibble))
		else $error("bus word lost under stall");
	chk_dout_release: assert property (spi_cs_n [*6] |-> !spi_dout_oe)
		else $error("serial output driven while deselected");
endmodule

bind rx_path_gain_filter_adc_control rx_ctrl_properties #(.CAL_CYCLES(CAL_CYCLES)) i_rx_ctrl_properties (
	.clock, .resetn, .spi_cs_n, .spi_dout_oe, .receive_gain_amp, .input_short, .offset_dac,
	.cutoff_cal_start, .cutoff_cal_busy, .converter_data_bus, .bus_valid, .bus_second_nibble,
	.bus_ready);

// File: verif/tb_rx_path_gain_filter_adc_control.sv
module tb_rx_path_gain_filter_adc_control
	import rx_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [6:0] addr; logic [7:0] wdata, rdata; logic [13:0] outs;} row_t;
	localparam int CAL = 20;
	localparam logic [6:0] RST_ADDR [4] = '{ADDR_CLOCK_CONFIG, ADDR_FILTER_ADC, ADDR_CUTOFF_TARGET, ADDR_ADC_BIAS};
	localparam logic [7:0] RST_VAL [4] = '{CLOCK_CONFIG_RST, FILTER_ADC_RST, CUTOFF_TARGET_RST, ADC_BIAS_RST};
	logic clock = 1'b0, resetn = 1'b0, ce = 1'b1, spi_clk = 1'b0, spi_cs_n = 1'b1, spi_din = 1'b0;
	logic gain_map_alt = 1'b0, duplex_full = 1'b0, rx_unused = 1'b0, adc_valid = 1'b0;
	logic [5:0] gain_code = 6'h00;
	logic [11:0] adc_sample = 12'h000, seq = 12'h000, converter_data_bus, word, last_word;
	logic [1:0] gen_q = 2'h0, stall_mode = 2'h0;
	logic spi_dout, spi_dout_oe, input_short, filter_bypass, cutoff_cal_start, cutoff_cal_busy;
	logic adc_low_power, adc_clk_from_pll, adc_power_down, bus_valid, bus_second_nibble, bus_ready;
	logic word_valid, chain_on = 1'b0, lat_chk = 1'b0;
	logic [7:0] offset_dac, cutoff_target, rd;
	logic [2:0] adc_bias;
	logic [8:0] exp_gain;
	gain_set_t receive_gain_amp;
	row_t rows [7];
	int num_errors = 0, comparisons = 0, cycles = 0, busy_len = 0, last_len = 0, starts = 0;
	int ofs_base = 100, n;

	rx_path_gain_filter_adc_control #(.CAL_CYCLES(CAL)) i_rx_path_gain_filter_adc_control (
		.clock, .resetn, .ce, .spi_clk, .spi_cs_n, .spi_din, .spi_dout, .spi_dout_oe, .gain_code,
		.gain_map_alt, .duplex_full, .rx_unused, .adc_valid, .adc_sample, .receive_gain_amp,
		.input_short, .offset_dac, .filter_bypass, .cutoff_target, .cutoff_cal_start,
		.cutoff_cal_busy, .adc_low_power, .adc_bias, .adc_clk_from_pll, .adc_power_down,
		.converter_data_bus, .bus_valid, .bus_second_nibble, .bus_ready);
	baseband_sink i_baseband_sink (.clock, .resetn, .stall_mode, .duplex(duplex_full), .bus_valid,
		.converter_data_bus, .bus_second_nibble, .bus_ready, .word, .word_valid);

	always #4 clock = ~clock;
	// ------
	// helpers
	// ------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// half period of six clocks leaves room for the pin synchronisers
	task automatic spi_frame(input logic rw, input logic [6:0] addr, input logic [7:0] wd,
		output logic [7:0] rdata);
		logic [15:0] frame;
		frame = {rw, addr, wd};
		rdata = 8'h00;
		spi_cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			spi_din <= frame[i];
			repeat (6) @(posedge clock);
			if (i < 8)
				rdata[i] = spi_dout;
			spi_clk <= 1'b1;
			repeat (6) @(posedge clock);
			spi_clk <= 1'b0;
		end
		repeat (6) @(posedge clock);
		spi_cs_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
	function automatic logic [8:0] gain_exp(input int idx);
		int c, f;
		if (idx > 60)
			idx = 60;
		c = (idx / 6 > 9) ? 9 : idx / 6;
		f = (c > 4) ? 4 : c;
		return {3'(f), 3'(c - f), 3'(idx - 6 * c)};
	endfunction
	// ------
	// converter stream: residual offset while shorted, a counting ramp otherwise
	// ------
	always @(posedge clock)
	begin
		gen_q <= gen_q + 2'h1;
		adc_valid <= (gen_q == 2'h3);
		if (gen_q == 2'h3)
		begin
			seq <= seq + 12'h001;
			adc_sample <= input_short ? 12'(ofs_base + 20 * $signed(offset_dac)) : seq + 12'h001;
		end
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cutoff_cal_start === 1'b1)
			starts++;
		if (cutoff_cal_busy === 1'b1)
			busy_len++;
		else if (busy_len != 0)
		begin
			last_len = busy_len;
			busy_len = 0;
		end
		if (word_valid === 1'b1)
		begin
			if (chain_on)
				check({4'h0, word}, {4'h0, last_word + 12'h001}, "order");
			last_word = word;
		end
		if (lat_chk && bus_valid === 1'b1 && bus_ready === 1'b1)
			check({4'h0, converter_data_bus}, {4'h0, seq - 12'(BUS_PIPE_STAGES)}, "latency");
		if (cycles == 20000)
		begin
			num_errors++;
			$display("mismatch at %0t: timeout", $time);
			results();
		end
	end
	// ------
	// main sequence
	// ------
	initial
	begin
		rows[0] = {7'h04, 8'h10, 8'h10, 14'h2080};
		rows[1] = {7'h07, 8'h10, 8'h10, 14'h3880};
		rows[2] = {7'h07, 8'h01, 8'h01, 14'h2080};
		rows[3] = {7'h13, 8'h05, 8'h05, 14'h2580};
		rows[4] = {7'h08, 8'h3C, 8'h3C, 14'h253C};
		rows[5] = {7'h30, 8'hFF, 8'h00, 14'h253C};
		rows[6] = {7'h04, 8'h00, 8'h00, 14'h053C};
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
		check({15'h0, filter_bypass}, 16'h0000, "bypass");
		for (int i = 0; i < 4; i++)
		begin
			spi_frame(1'b1, RST_ADDR[i], 8'h00, rd);
			check({8'h00, rd}, {8'h00, RST_VAL[i]}, "reset value");
		end
		for (n = 0; n < 2000 && input_short !== 1'b0; n++)
			@(posedge clock);
		check({8'h00, offset_dac}, 16'h00FC, "dac");
		for (int i = 0; i < 72; i++)
		begin
			gain_map_alt <= (i > 63);
			gain_code <= 6'(i > 63 ? i - 64 : i);
			exp_gain = gain_exp(i > 63 ? 8 * (i > 70 ? 6 : i - 64) : i);
			repeat (6) @(posedge clock);
			check({7'h00, receive_gain_amp}, {7'h00, exp_gain}, "gain");
		end
		for (int i = 0; i < 7; i++)
		begin
			spi_frame(1'b0, rows[i].addr, rows[i].wdata, rd);
			spi_frame(1'b1, rows[i].addr, 8'h00, rd);
			check({8'h00, rd}, {8'h00, rows[i].rdata}, "readback");
			check({2'h0, adc_clk_from_pll, filter_bypass, adc_low_power, adc_bias, cutoff_target},
				{2'h0, rows[i].outs}, "outputs");
		end
		starts = 0;
		spi_frame(1'b0, ADDR_CUTOFF_TARGET, 8'h3C, rd);
		for (n = 0; n < 200 && cutoff_cal_busy !== 1'b0; n++)
			@(posedge clock);
		repeat (2) @(posedge clock);
		check(16'(starts), 16'h0001, "rewrite");
		check(16'(last_len), 16'(CAL), "cal time");
		ofs_base = -100;
		spi_frame(1'b0, ADDR_CAL_CONTROL, 8'h01, rd);
		check({15'h0, input_short}, 16'h0001, "restart");
		for (n = 0; n < 2000 && input_short !== 1'b0; n++)
			@(posedge clock);
		check({8'h00, offset_dac}, 16'h0004, "dac");
		lat_chk = 1'b1;
		repeat (80) @(posedge clock);
		chain_on = 1'b1;
		repeat (100) @(posedge clock);
		lat_chk = 1'b0;
		stall_mode <= 2'h1;
		repeat (200) @(posedge clock);
		stall_mode <= 2'h2;
		repeat (60) @(posedge clock);
		check({15'h0, bus_valid}, 16'h0001, "full");
		stall_mode <= 2'h0;
		repeat (30) @(posedge clock);
		chain_on = 1'b0;
		duplex_full <= 1'b1;
		repeat (80) @(posedge clock);
		chain_on = 1'b1;
		repeat (100) @(posedge clock);
		chain_on = 1'b0;
		rx_unused <= 1'b1;
		repeat (6) @(posedge clock);
		check({15'h0, adc_power_down}, 16'h0000, "powerdown");
		duplex_full <= 1'b0;
		repeat (6) @(posedge clock);
		check({15'h0, adc_power_down}, 16'h0001, "powerdown");
		rx_unused <= 1'b0;
		repeat (6) @(posedge clock);
		check({15'h0, adc_power_down}, 16'h0000, "powerdown");
		ce <= 1'b0;
		spi_frame(1'b0, ADDR_ADC_BIAS, 8'h02, rd);
		ce <= 1'b1;
		spi_frame(1'b1, ADDR_ADC_BIAS, 8'h00, rd);
		check({8'h00, rd}, 16'h0005, "frozen");
		results();
	end
endmodule
